// ===== inc/scdc_pkg.sv
/*
  scdc_pkg: constants, register layouts and mode codes for the socket card device control block.
  assumes: 32-bit APB, registers in the low byte of aligned words, 200 MHz clock.
*/
package scdc_pkg;

  localparam int NSOCK = 2;
  localparam int ADDR_W = 12;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [9:0] CARD_CTRL0_IDX = 10'h091;
  localparam logic [9:0] DEV_CTRL_IDX = 10'h092;
  localparam logic [9:0] CARD_CTRL1_IDX = 10'h0B1;
  localparam logic [9:0] IRQ_STAT_IDX = 10'h0C0;
  localparam logic [9:0] IRQ_MASK_IDX = 10'h0C1;
  localparam logic [ADDR_W-1:0] CARD_CTRL0_ADDR = {CARD_CTRL0_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] DEV_CTRL_ADDR = {DEV_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CARD_CTRL1_ADDR = {CARD_CTRL1_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'h0};

  // card control field positions
  localparam int CC_RING_BIT = 7;
  localparam int CC_VIDEO_BIT = 6;
  localparam int CC_AUDIO_BIT = 2;
  localparam int CC_CARD_SPEAKER_IN_BIT = 1;
  localparam int CC_FLAG_BIT = 0;

  typedef struct packed {
    logic ring_indicate_enable;
    logic video_port_compat_enable;
    logic [2:0] rsvd;
    logic audio_route_select;
    logic speaker_passthrough_enable;
    logic socket_interrupt_flag;
  } scdc_card_ctrl_t;

  typedef struct packed {
    logic socket_power_hold;
    logic low_voltage_capable_force;
    logic diag_bit_five;
    logic rsvd;
    logic test_short_interrog;
    logic [1:0] interrupt_signal_select;
    logic nand_tree_enable;
  } scdc_dev_ctrl_t;

  localparam logic [7:0] CARD_CTRL_RST = 8'h00;
  localparam logic [7:0] DEV_CTRL_RST = 8'h66;
  localparam logic [NSOCK-1:0] IRQ_MASK_RST = 2'h0;

  localparam logic [1:0] MODE_PAR_PCI = 2'h0;
  localparam logic [1:0] MODE_PAR_IRQ_PCI = 2'h1;
  localparam logic [1:0] MODE_SER_IRQ = 2'h2;
  localparam logic [1:0] MODE_SER_ALL = 2'h3;

  // card interrogation period, normal and shortened by the test bit
  localparam int CLK_PERIOD_PS = 5000;
  localparam int INTERROG_TIME_NS = 10000;
  localparam int INTERROG_LONG_CYC = (INTERROG_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int INTERROG_SHORT_CYC = 16;
  localparam int INTERROG_W = 12;

endpackage : scdc_pkg

// ===== design/scdc_top.sv
/*
  scdc_top: card control and device control registers of a card socket bridge, APB slave,
  socket signal gating, socket interrupt flags, interrupt status/mask, interrogation timer.
  assumes: socket pins are asynchronous and pass two flip-flops; power requests and the
  D3 indication come from logic on CLK; an outside pad ring resolves the enables.
*/
// The APB register port was chosen for this implementation.
// Overview of operation
// - ring indicate output is driven only while its enable bit 7 is one.
// - video port compat bit 6 set puts socket video terminals in high impedance.
// - audio bit 2 clear routes card audio as PWM to multifunction terminal.
// - when both functions request audio routing, function 0 audio is routed.
// - speaker bit 1 set passes card speaker to host speaker output.
// - functional interrupt from a socket sets that socket's own flag bit 0.
// - writing one to the flag clears it; flag resets to zero.
// - card control bits 5 to 3 are read-only and read zero.
// - power hold bit 7 set blocks socket power-down requests while in D3.
// - bit 6 is a writable 3-V capable force bit, reset one.
// - bit 5 is a read/write diagnostic bit, reset one.
// - device control bit 4 reads zero and ignores writes.
// - test bit 3 set shortens the card interrogation counter; software writes zero.
// - bits 2 to 1 select interrupt signalling mode, reset to fully serialized.
// - bit 0 enables a NAND tree over input terminals only.
`timescale 1ns/10ps
module scdc_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [scdc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [scdc_pkg::NSOCK-1:0] CARD_FUNC_IRQ,
  input wire logic [scdc_pkg::NSOCK-1:0] CARD_SPEAKER_IN,
  input wire logic [scdc_pkg::NSOCK-1:0] CARD_AUDIO_SIGNAL,
  input wire logic [scdc_pkg::NSOCK-1:0] CARD_RING_IN,
  input wire logic [scdc_pkg::NSOCK-1:0] SOCKET_POWER_ON_REQ,
  input wire logic [scdc_pkg::NSOCK-1:0] SOCKET_POWER_OFF_REQ,
  input wire logic IN_D3,
  output logic [scdc_pkg::NSOCK-1:0] SOCKET_POWERED,
  output logic RING_INDICATE_OUTPUT,
  output logic RING_INDICATE_OE_N,
  output logic [scdc_pkg::NSOCK-1:0] VIDEO_PORT_OE_N,
  output logic MULTIFUNCTION_TERMINAL,
  output logic MULTIFUNCTION_TERMINAL_OE_N,
  output logic HOST_SPEAKER_OUTPUT,
  output logic LOW_VOLTAGE_CAPABLE,
  output logic INTERROGATION_TICK,
  output logic PARALLEL_IRQ_EN,
  output logic SERIAL_IRQ_EN,
  output logic SERIAL_PCI_EN,
  output logic NAND_TREE_ENABLE,
  output logic NAND_TREE_OUT,
  output logic IRQ
);

  localparam int NS = scdc_pkg::NSOCK;
  localparam int NIN = 4 * scdc_pkg::NSOCK;

  scdc_pkg::scdc_card_ctrl_t card_q [NS];
  scdc_pkg::scdc_dev_ctrl_t dev_q;
  logic [NS-1:0] stat_q;
  logic [NS-1:0] mask_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;
  logic [NS-1:0] irq_prev_q;
  logic [NS-1:0] irq_rise;
  logic [NS-1:0] func_sync;
  logic [NS-1:0] card_speaker_in_sync;
  logic [NS-1:0] audio_sync;
  logic [NS-1:0] ring_sync;
  logic [NS-1:0] powered_q;
  logic [scdc_pkg::INTERROG_W-1:0] cnt_q;
  logic [scdc_pkg::INTERROG_W-1:0] cnt_limit;
  logic tick_q;
  logic ring_q;
  logic ring_oe_n_q;
  logic [NS-1:0] video_oe_n_q;
  logic mft_q;
  logic mft_oe_n_q;
  logic card_speaker_in_q;
  logic par_irq_q;
  logic ser_irq_q;
  logic ser_pci_q;
  logic nand_q;
  logic irq_q;
  logic setup;
  logic wr_en;
  logic addr_hit;
  logic [NS-1:0] ring_en;
  logic [NS-1:0] card_speaker_in_en;

  // socket pins: two stages, nothing reads meta_q but sync_q
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {CARD_RING_IN, CARD_AUDIO_SIGNAL, CARD_SPEAKER_IN, CARD_FUNC_IRQ};
      sync_q <= meta_q;
    end
  end

  assign func_sync = sync_q[NS-1:0];
  assign card_speaker_in_sync = sync_q[2*NS-1:NS];
  assign audio_sync = sync_q[3*NS-1:2*NS];
  assign ring_sync = sync_q[4*NS-1:3*NS];

  always_ff @(posedge CLK)
  begin
    if (RST)
      irq_prev_q <= '0;
    else
      irq_prev_q <= func_sync;
  end

  assign irq_rise = func_sync & ~irq_prev_q;

  // apb: answer in the first access cycle; write takes effect at that edge
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE & pready_q & ~pslverr_q & PSTRB[0];

  always_comb
  begin
    addr_hit = 1'b0;
    case (PADDR)
      scdc_pkg::CARD_CTRL0_ADDR: addr_hit = 1'b1;
      scdc_pkg::CARD_CTRL1_ADDR: addr_hit = 1'b1;
      scdc_pkg::DEV_CTRL_ADDR: addr_hit = 1'b1;
      scdc_pkg::IRQ_STAT_ADDR: addr_hit = 1'b1;
      scdc_pkg::IRQ_MASK_ADDR: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~addr_hit;
    end
  end

  // read data latched in setup; reserved bits come back zero from the struct fields
  always_ff @(posedge CLK)
  begin
    if (RST)
      prdata_q <= 32'h0000_0000;
    else if (setup)
    begin
      case (PADDR)
        scdc_pkg::CARD_CTRL0_ADDR: prdata_q <= {24'h00_0000, card_q[0]};
        scdc_pkg::CARD_CTRL1_ADDR: prdata_q <= {24'h00_0000, card_q[1]};
        scdc_pkg::DEV_CTRL_ADDR: prdata_q <= {24'h00_0000, dev_q};
        scdc_pkg::IRQ_STAT_ADDR: prdata_q <= {30'h0000_0000, stat_q};
        scdc_pkg::IRQ_MASK_ADDR: prdata_q <= {30'h0000_0000, mask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // card control, one copy per socket
  always_ff @(posedge CLK)
  begin
    for (int i = 0; i < NS; i++)
    begin
      if (RST)
        card_q[i] <= scdc_pkg::scdc_card_ctrl_t'(scdc_pkg::CARD_CTRL_RST);
      else
      begin
        if (wr_en && PADDR == ((i == 0) ? scdc_pkg::CARD_CTRL0_ADDR : scdc_pkg::CARD_CTRL1_ADDR))
        begin
          card_q[i].ring_indicate_enable <= PWDATA[scdc_pkg::CC_RING_BIT];
          card_q[i].video_port_compat_enable <= PWDATA[scdc_pkg::CC_VIDEO_BIT];
          card_q[i].audio_route_select <= PWDATA[scdc_pkg::CC_AUDIO_BIT];
          card_q[i].speaker_passthrough_enable <= PWDATA[scdc_pkg::CC_CARD_SPEAKER_IN_BIT];
          // set wins over the write-one clear
          card_q[i].socket_interrupt_flag <= irq_rise[i] |
            (card_q[i].socket_interrupt_flag & ~PWDATA[scdc_pkg::CC_FLAG_BIT]);
        end
        else if (irq_rise[i])
          card_q[i].socket_interrupt_flag <= 1'b1;
        card_q[i].rsvd <= 3'h0;
      end
    end
  end

  // device control; bit 4 never stored
  always_ff @(posedge CLK)
  begin
    if (RST)
      dev_q <= scdc_pkg::scdc_dev_ctrl_t'(scdc_pkg::DEV_CTRL_RST);
    else if (wr_en && PADDR == scdc_pkg::DEV_CTRL_ADDR)
    begin
      dev_q.socket_power_hold <= PWDATA[7];
      dev_q.low_voltage_capable_force <= PWDATA[6];
      dev_q.diag_bit_five <= PWDATA[5];
      dev_q.rsvd <= 1'b0;
      dev_q.test_short_interrog <= PWDATA[3];
      dev_q.interrupt_signal_select <= PWDATA[2:1];
      dev_q.nand_tree_enable <= PWDATA[0];
    end
  end

  // interrupt status: sticky, write one to clear, set wins
  always_ff @(posedge CLK)
  begin
    if (RST)
      stat_q <= '0;
    else if (wr_en && PADDR == scdc_pkg::IRQ_STAT_ADDR)
      stat_q <= irq_rise | (stat_q & ~PWDATA[NS-1:0]);
    else
      stat_q <= stat_q | irq_rise;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      mask_q <= scdc_pkg::IRQ_MASK_RST;
    else if (wr_en && PADDR == scdc_pkg::IRQ_MASK_ADDR)
      mask_q <= PWDATA[NS-1:0];
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

  // socket power; a locked socket in D3 ignores power-down
  always_ff @(posedge CLK)
  begin
    if (RST)
      powered_q <= '0;
    else
    begin
      for (int i = 0; i < NS; i++)
      begin
        if (SOCKET_POWER_ON_REQ[i])
          powered_q[i] <= 1'b1;
        else if (SOCKET_POWER_OFF_REQ[i] && !(dev_q.socket_power_hold && IN_D3))
          powered_q[i] <= 1'b0;
      end
    end
  end

  // socket signal gating
  always_comb
  begin
    ring_en = '0;
    card_speaker_in_en = '0;
    for (int i = 0; i < NS; i++)
    begin
      ring_en[i] = card_q[i].ring_indicate_enable;
      card_speaker_in_en[i] = card_q[i].speaker_passthrough_enable;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ring_q <= 1'b0;
      ring_oe_n_q <= 1'b1;
      card_speaker_in_q <= 1'b0;
    end
    else
    begin
      ring_q <= |(ring_sync & ring_en);
      ring_oe_n_q <= ~|ring_en;
      card_speaker_in_q <= |(card_speaker_in_sync & card_speaker_in_en);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      video_oe_n_q <= '0;
    else
      for (int i = 0; i < NS; i++)
        video_oe_n_q[i] <= card_q[i].video_port_compat_enable;
  end

  // audio: a clear select bit asks for routing; function 0 has priority
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      mft_q <= 1'b0;
      mft_oe_n_q <= 1'b1;
    end
    else if (!card_q[0].audio_route_select)
    begin
      mft_q <= audio_sync[0];
      mft_oe_n_q <= 1'b0;
    end
    else if (!card_q[1].audio_route_select)
    begin
      mft_q <= audio_sync[1];
      mft_oe_n_q <= 1'b0;
    end
    else
    begin
      mft_q <= 1'b0;
      mft_oe_n_q <= 1'b1;
    end
  end

  // interrogation timer; >= compare keeps the count sane when the period shrinks
  assign cnt_limit = dev_q.test_short_interrog ?
    scdc_pkg::INTERROG_W'(scdc_pkg::INTERROG_SHORT_CYC - 1) :
    scdc_pkg::INTERROG_W'(scdc_pkg::INTERROG_LONG_CYC - 1);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (cnt_q >= cnt_limit)
    begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // mode decode
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      par_irq_q <= 1'b0;
      ser_irq_q <= 1'b1;
      ser_pci_q <= 1'b1;
    end
    else
    begin
      par_irq_q <= dev_q.interrupt_signal_select == scdc_pkg::MODE_PAR_IRQ_PCI;
      ser_irq_q <= dev_q.interrupt_signal_select == scdc_pkg::MODE_SER_IRQ ||
        dev_q.interrupt_signal_select == scdc_pkg::MODE_SER_ALL;
      ser_pci_q <= dev_q.interrupt_signal_select == scdc_pkg::MODE_SER_ALL;
    end
  end

  // nand tree over synchronised input pins only; outputs never feed it
  always_ff @(posedge CLK)
  begin
    if (RST)
      nand_q <= 1'b0;
    else
      nand_q <= dev_q.nand_tree_enable & ~&sync_q;
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign SOCKET_POWERED = powered_q;
  assign RING_INDICATE_OUTPUT = ring_q;
  assign RING_INDICATE_OE_N = ring_oe_n_q;
  assign VIDEO_PORT_OE_N = video_oe_n_q;
  assign MULTIFUNCTION_TERMINAL = mft_q;
  assign MULTIFUNCTION_TERMINAL_OE_N = mft_oe_n_q;
  assign HOST_SPEAKER_OUTPUT = card_speaker_in_q;
  assign LOW_VOLTAGE_CAPABLE = dev_q.low_voltage_capable_force;
  assign INTERROGATION_TICK = tick_q;
  assign PARALLEL_IRQ_EN = par_irq_q;
  assign SERIAL_IRQ_EN = ser_irq_q;
  assign SERIAL_PCI_EN = ser_pci_q;
  assign NAND_TREE_ENABLE = dev_q.nand_tree_enable;
  assign NAND_TREE_OUT = nand_q;
  assign IRQ = irq_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_flag_set: assert property (irq_rise[0] |=> card_q[0].socket_interrupt_flag)
    else $error("socket 0 flag not set by event");
  a_flag_wone_clear: assert property (wr_en && PADDR == scdc_pkg::CARD_CTRL0_ADDR && PWDATA[0]
    && !irq_rise[0] |=> !card_q[0].socket_interrupt_flag)
    else $error("socket 0 flag not cleared by write one");
  a_ring_gated: assert property (ring_en == '0 |=> !RING_INDICATE_OUTPUT && RING_INDICATE_OE_N)
    else $error("ring output active while disabled");
  a_video_hiz: assert property (card_q[1].video_port_compat_enable |=> VIDEO_PORT_OE_N[1])
    else $error("video port driven in compat mode");
  a_audio_fn0: assert property (!card_q[0].audio_route_select |=>
    !MULTIFUNCTION_TERMINAL_OE_N && MULTIFUNCTION_TERMINAL == $past(audio_sync[0]))
    else $error("function 0 audio not routed");
  a_audio_none: assert property (card_q[0].audio_route_select && card_q[1].audio_route_select
    |=> MULTIFUNCTION_TERMINAL_OE_N)
    else $error("audio routed while both selects set");
  a_card_speaker_in_gated: assert property (card_speaker_in_en == '0 |=> !HOST_SPEAKER_OUTPUT)
    else $error("speaker passed while disabled");
  a_card_rsvd_zero: assert property (PREADY && PADDR == scdc_pkg::CARD_CTRL0_ADDR |->
    PRDATA[5:3] == 3'h0)
    else $error("card control reserved bits read nonzero");
  a_power_hold: assert property (dev_q.socket_power_hold && IN_D3 && SOCKET_POWER_OFF_REQ[0]
    && powered_q[0] |=> powered_q[0])
    else $error("locked socket powered down in D3");
  a_dev_write: assert property (wr_en && PADDR == scdc_pkg::DEV_CTRL_ADDR |=>
    dev_q[6:5] == $past(PWDATA[6:5]) && dev_q[4] == 1'b0)
    else $error("device control write not stored");
  a_short_count: assert property (dev_q.test_short_interrog && $past(dev_q.test_short_interrog) |->
    cnt_q < scdc_pkg::INTERROG_SHORT_CYC)
    else $error("interrogation count not shortened");
  a_mode_decode: assert property (##1 SERIAL_PCI_EN == ($past(dev_q.interrupt_signal_select) == 2'h3)
    && PARALLEL_IRQ_EN == ($past(dev_q.interrupt_signal_select) == 2'h1))
    else $error("interrupt mode decode wrong");
  a_nand_off: assert property (!dev_q.nand_tree_enable |=> !NAND_TREE_OUT)
    else $error("nand tree active while disabled");

  c_flag_collide: cover property (irq_rise[0] && wr_en && PADDR == scdc_pkg::CARD_CTRL0_ADDR && PWDATA[0]);
  c_audio_fn1: cover property (card_q[0].audio_route_select && !card_q[1].audio_route_select);
  c_power_locked: cover property (dev_q.socket_power_hold && IN_D3 && SOCKET_POWER_OFF_REQ[1]);
  c_irq_out: cover property ($rose(IRQ));

endmodule : scdc_top

// ===== testbench/scdc_socket_model.sv
/*
  scdc_socket_model: behavioural card socket pair driving the card-side pins of the bridge.
  assumes: the bench commands pin levels; pins change just after a rising CLK edge.
*/
`timescale 1ns/10ps
module scdc_socket_model (
  input wire logic clk,
  input wire logic [1:0] irq_cmd,
  input wire logic [1:0] spk_cmd,
  input wire logic [1:0] aud_cmd,
  input wire logic [1:0] ring_cmd,
  output logic [1:0] func_irq,
  output logic [1:0] speaker,
  output logic [1:0] audio,
  output logic [1:0] ring
);
  // each socket raises its own functional interrupt level, held until told to drop
  always_ff @(posedge clk)
  begin
    func_irq <= irq_cmd;
  end

  // card levels; real cards are asynchronous, the bridge syncs them anyway
  always_ff @(posedge clk)
  begin
    speaker <= spk_cmd;
    audio <= aud_cmd;
    ring <= ring_cmd;
  end
endmodule : scdc_socket_model

// ===== testbench/scdc_top_tb.sv
/*
  scdc_top_tb: self-checking bench for the card and device control registers, APB master, model.
  assumes: zero-wait APB slave, socket pins reach outputs within six cycles.
*/
`timescale 1ns/10ps
module scdc_top_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, in_d3;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [1:0] irq_pin, spk_pin, aud_pin, ring_pin, irq_cmd, spk_cmd, aud_cmd, ring_cmd;
  logic [1:0] pon, poff, powered, video_oe_n;
  logic ring_out, ring_oe_n, mft, mft_oe_n, spk_out, lvc, tick, par_en, sirq_en, spci_en, nand_en, irq;
  logic nand_out;
  logic rerr;
  logic [31:0] rdat;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int cc[2];
  int dc, st, mk;

  scdc_socket_model sock (.clk(clk), .irq_cmd(irq_cmd), .spk_cmd(spk_cmd), .aud_cmd(aud_cmd),
    .ring_cmd(ring_cmd), .func_irq(irq_pin), .speaker(spk_pin), .audio(aud_pin), .ring(ring_pin));

  scdc_top uut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CARD_FUNC_IRQ(irq_pin), .CARD_SPEAKER_IN(spk_pin), .CARD_AUDIO_SIGNAL(aud_pin),
    .CARD_RING_IN(ring_pin), .SOCKET_POWER_ON_REQ(pon), .SOCKET_POWER_OFF_REQ(poff), .IN_D3(in_d3),
    .SOCKET_POWERED(powered), .RING_INDICATE_OUTPUT(ring_out), .RING_INDICATE_OE_N(ring_oe_n),
    .VIDEO_PORT_OE_N(video_oe_n), .MULTIFUNCTION_TERMINAL(mft), .MULTIFUNCTION_TERMINAL_OE_N(mft_oe_n),
    .HOST_SPEAKER_OUTPUT(spk_out), .LOW_VOLTAGE_CAPABLE(lvc), .INTERROGATION_TICK(tick),
    .PARALLEL_IRQ_EN(par_en), .SERIAL_IRQ_EN(sirq_en), .SERIAL_PCI_EN(spci_en),
    .NAND_TREE_ENABLE(nand_en), .NAND_TREE_OUT(nand_out), .IRQ(irq));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // the whole run needs under 10000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      complete_run();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp

  // request held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
    case (a)
      scdc_pkg::CARD_CTRL0_ADDR: cc[0] = (d & 'hC6) | (cc[0] & ~d & 1);
      scdc_pkg::CARD_CTRL1_ADDR: cc[1] = (d & 'hC6) | (cc[1] & ~d & 1);
      scdc_pkg::DEV_CTRL_ADDR: dc = d & 'hEF;
      scdc_pkg::IRQ_STAT_ADDR: st = st & ~d & 3;
      scdc_pkg::IRQ_MASK_ADDR: mk = d & 3;
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic [31:0] r;
    logic e;
    int x;
    logic ee;
    x = 0;
    ee = 1'b0;
    case (a)
      scdc_pkg::CARD_CTRL0_ADDR: x = cc[0];
      scdc_pkg::CARD_CTRL1_ADDR: x = cc[1];
      scdc_pkg::DEV_CTRL_ADDR: x = dc;
      scdc_pkg::IRQ_STAT_ADDR: x = st;
      scdc_pkg::IRQ_MASK_ADDR: x = mk;
      default: ee = 1'b1;
    endcase
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, 32'(x));
    cmp(32'(e), 32'(ee));
  endtask : rd

  // outputs are worked out from the model registers and the present pin levels
  task automatic outs;
    logic [7:0] a, b, d;
    a = 8'(cc[0]);
    b = 8'(cc[1]);
    d = 8'(dc);
    cmp(32'({ring_oe_n, ring_out}), 32'({~(a[7] | b[7]), |(ring_pin & {b[7], a[7]})}));
    cmp(32'(video_oe_n), 32'({b[6], a[6]}));
    cmp(32'(mft_oe_n), 32'(a[2] & b[2]));
    if (!(a[2] && b[2]))
      cmp(32'(mft), 32'(a[2] ? aud_pin[1] : aud_pin[0]));
    cmp(32'(spk_out), 32'(|(spk_pin & {b[1], a[1]})));
    cmp(32'({lvc, nand_en}), 32'({d[6], d[0]}));
    cmp(32'(nand_out), 32'(d[0] & ~&{ring_pin, aud_pin, spk_pin, irq_pin}));
    cmp(32'({par_en, sirq_en, spci_en}), 32'({d[2:1] == 2'h1, d[2], d[2:1] == 2'h3}));
  endtask : outs

  task automatic pwr(input logic on, input logic [1:0] v);
    @(posedge clk);
    if (on)
      pon <= v;
    else
      poff <= v;
    @(posedge clk);
    pon <= 2'h0;
    poff <= 2'h0;
    repeat (2) @(posedge clk);
  endtask : pwr

  // the first gap after a mode change may still run the old count, so skip it
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    repeat (2)
      do @(posedge clk); while (tick !== 1'b1);
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'b1);
    cmp(32'(n), 32'(exp));
  endtask : tick_gap

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, in_d3} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    {irq_cmd, spk_cmd, aud_cmd, ring_cmd, pon, poff} = 12'h000;
    cc[0] = 0;
    cc[1] = 0;
    dc = 'h66;
    st = 0;
    mk = 0;
    void'($urandom(87258));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(scdc_pkg::CARD_CTRL0_ADDR);
    rd(scdc_pkg::CARD_CTRL1_ADDR);
    rd(scdc_pkg::DEV_CTRL_ADDR);
    rd(scdc_pkg::IRQ_STAT_ADDR);
    rd(scdc_pkg::IRQ_MASK_ADDR);
    wr(12'h000, 8'hFF);
    rd(12'h000);
    rd(scdc_pkg::DEV_CTRL_ADDR);
    outs();
    $display("test reset values done");
    // test bit kept zero by software; mode walks all four codes
    for (int i = 0; i < 24; i++)
    begin
      wr(scdc_pkg::CARD_CTRL0_ADDR, 8'($urandom));
      wr(scdc_pkg::CARD_CTRL1_ADDR, 8'($urandom));
      wr(scdc_pkg::DEV_CTRL_ADDR, (8'($urandom) & 8'hF1) | 8'((i % 4) << 1));
      ring_cmd <= 2'($urandom);
      spk_cmd <= 2'($urandom);
      aud_cmd <= 2'($urandom);
      repeat (6) @(posedge clk);
      outs();
      rd(scdc_pkg::CARD_CTRL0_ADDR);
      rd(scdc_pkg::CARD_CTRL1_ADDR);
      rd(scdc_pkg::DEV_CTRL_ADDR);
    end
    $display("test random control done");
    wr(scdc_pkg::DEV_CTRL_ADDR, 8'h66);
    wr(scdc_pkg::CARD_CTRL0_ADDR, 8'h00);
    wr(scdc_pkg::CARD_CTRL1_ADDR, 8'h00);
    irq_cmd <= 2'h2;
    repeat (6) @(posedge clk);
    cc[1] = 1;
    st = 2;
    rd(scdc_pkg::CARD_CTRL0_ADDR);
    rd(scdc_pkg::CARD_CTRL1_ADDR);
    rd(scdc_pkg::IRQ_STAT_ADDR);
    cmp(32'(irq), 32'h0);
    wr(scdc_pkg::IRQ_MASK_ADDR, 8'h03);
    repeat (2) @(posedge clk);
    cmp(32'(irq), 32'h1);
    irq_cmd <= 2'h0;
    wr(scdc_pkg::CARD_CTRL1_ADDR, 8'h01);
    rd(scdc_pkg::CARD_CTRL1_ADDR);
    wr(scdc_pkg::IRQ_STAT_ADDR, 8'h02);
    rd(scdc_pkg::IRQ_STAT_ADDR);
    repeat (2) @(posedge clk);
    cmp(32'(irq), 32'h0);
    // socket 0 event lands on the edge of a write-one clear: the event must survive
    irq_cmd <= 2'h1;
    @(posedge clk);
    wr(scdc_pkg::CARD_CTRL0_ADDR, 8'h01);
    cc[0] = 1;
    st = 1;
    rd(scdc_pkg::CARD_CTRL0_ADDR);
    rd(scdc_pkg::IRQ_STAT_ADDR);
    irq_cmd <= 2'h0;
    wr(scdc_pkg::CARD_CTRL0_ADDR, 8'h01);
    wr(scdc_pkg::IRQ_STAT_ADDR, 8'h01);
    rd(scdc_pkg::CARD_CTRL0_ADDR);
    rd(scdc_pkg::IRQ_STAT_ADDR);
    $display("test socket interrupt done");
    pwr(1'b1, 2'h3);
    cmp(32'(powered), 32'h3);
    wr(scdc_pkg::DEV_CTRL_ADDR, 8'hE6);
    in_d3 <= 1'b1;
    pwr(1'b0, 2'h3);
    cmp(32'(powered), 32'h3);
    wr(scdc_pkg::DEV_CTRL_ADDR, 8'h66);
    pwr(1'b0, 2'h1);
    cmp(32'(powered), 32'h2);
    in_d3 <= 1'b0;
    $display("test power hold done");
    // a write with the low byte strobe clear must leave the mask alone
    pstrb <= 4'hE;
    apb(1'b1, scdc_pkg::IRQ_MASK_ADDR, 32'h0, rdat, rerr);
    pstrb <= 4'hF;
    rd(scdc_pkg::IRQ_MASK_ADDR);
    $display("test write strobe done");
    tick_gap(scdc_pkg::INTERROG_LONG_CYC);
    wr(scdc_pkg::DEV_CTRL_ADDR, 8'h6E);
    tick_gap(scdc_pkg::INTERROG_SHORT_CYC);
    wr(scdc_pkg::DEV_CTRL_ADDR, 8'h66);
    $display("test interrogation done");
    complete_run();
  end
endmodule : scdc_top_tb
